// >>> hw/dchb_bus_if.sv
// Processor multiplexed bus between host side and controller side
interface dchb_bus_if;
  import dchb_pkg::*;

  logic            ale;
  logic            rd_n;
  logic            wr_n;
  logic            burst_or_near_write_n;
  logic            cs_n;
  logic            mode_register_select_n;
  logic [AD_W-1:0] ad;
  logic [1:0]      addr_lo;
  logic            read_data_latch_enable_n_o;
  logic            read_data_latch_enable_n_oe;
  logic            ack_n_o;
  logic            ack_n_oe;
  logic            read_data_latch_enable_n;
  logic            ack_n;

  // Released outputs float high through the pull-up
  assign read_data_latch_enable_n = read_data_latch_enable_n_oe ?
                                    read_data_latch_enable_n_o : 1'b1;
  assign ack_n = ack_n_oe ? ack_n_o : 1'b1;

  modport device (
    input  ale, rd_n, wr_n, burst_or_near_write_n, cs_n, mode_register_select_n,
    input  ad, addr_lo,
    output read_data_latch_enable_n_o, read_data_latch_enable_n_oe, ack_n_o, ack_n_oe
  );

  modport host (
    output ale, rd_n, wr_n, burst_or_near_write_n, cs_n, mode_register_select_n,
    output ad, addr_lo,
    input  read_data_latch_enable_n, ack_n
  );
endinterface

// >>> hw/dchb_device.sv
// Controller end: cycle decode, address latch and mapping, mode register
module dchb_device
(
  input  wire logic                     ref_clk,
  input  wire logic                     arst_n,
  dchb_bus_if.device                    bus,
  output logic [dchb_pkg::MODE_W-1:0]   mode_reg,
  output logic                          mem_req,
  output dchb_pkg::dchb_cyc_e           mem_cyc,
  output logic [dchb_pkg::DADDR_W-1:0]  mem_row,
  output logic [dchb_pkg::DADDR_W-1:0]  mem_col,
  output logic [dchb_pkg::BANKS-1:0]    mem_bank,
  output logic                          mem_active,
  input  wire logic                     mem_ack,
  input  wire logic                     mem_rdce
);
  import dchb_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_MODE = 5'h04,
    ST_MEM  = 5'h08,
    ST_END  = 5'h10
  } dchb_dev_state_e;

  dchb_dev_state_e      state_ff, nxt_state;
  logic [WADDR_W-1:0]   waddr_ff, nxt_waddr;
  logic [MODE_W-1:0]    mode_ff, nxt_mode;
  logic [1:0]           cnt_ff, nxt_cnt;
  logic                 mode_wr_ff, nxt_mode_wr;
  logic                 sel_ff, nxt_sel;
  logic                 ack_n_ff, nxt_ack_n;
  logic                 rdce_n_ff, nxt_rdce_n;
  logic                 req_ff, nxt_req;
  dchb_cyc_e            cyc_ff, nxt_cyc;
  dchb_dram_addr_s      daddr_ff, nxt_daddr;
  logic                 strobe;
  logic                 strobes_off;
  logic [1:0]           last_cnt;

  assign strobe      = ~bus.rd_n | ~bus.wr_n;
  assign strobes_off = bus.rd_n & bus.wr_n;
  // Ack registered one edge ahead so it stands in the last strobe cycle
  assign last_cnt    = 2'(MODE_WR_CYC - 2);

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_waddr   = waddr_ff;
    nxt_mode    = mode_ff;
    nxt_cnt     = cnt_ff;
    nxt_mode_wr = mode_wr_ff;
    nxt_sel     = sel_ff;
    nxt_ack_n   = 1'b1;
    nxt_rdce_n  = 1'b1;
    nxt_req     = 1'b0;
    nxt_cyc     = cyc_ff;
    nxt_daddr   = daddr_ff;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_sel = 1'b0;
        if (bus.ale)
        begin
          nxt_waddr = {bus.ad[AD_W-1:4], bus.addr_lo};
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        if (bus.ale)
        begin
          nxt_waddr = {bus.ad[AD_W-1:4], bus.addr_lo};
        end
        else if (strobe)
        begin
          // Cycle type from strobes and burst/near-write
          if (!bus.rd_n)
            nxt_cyc = bus.burst_or_near_write_n ? CYC_RD : CYC_BURST_RD;
          else
            nxt_cyc = bus.burst_or_near_write_n ? CYC_WR : CYC_NEAR_WR;
          nxt_sel = ~bus.cs_n;
          if (bus.cs_n)
          begin
            nxt_state = ST_END;
          end
          else if (!bus.mode_register_select_n)
          begin
            nxt_mode_wr = ~bus.wr_n;
            nxt_cnt     = 2'h1;
            nxt_state   = ST_MODE;
          end
          else
          begin
            nxt_daddr = map_addr(waddr_ff, mode_ff[MODE_DZ_LSB +: 2],
                                 mode_ff[MODE_INLV_BIT]);
            nxt_req   = 1'b1;
            nxt_state = ST_MEM;
          end
        end
      end
      ST_MODE:
      begin
        if (cnt_ff == last_cnt)
        begin
          nxt_ack_n = 1'b0;
          if (mode_wr_ff)
            nxt_mode = bus.ad[MODE_W-1:0];
          nxt_state = ST_END;
        end
        else
        begin
          nxt_cnt = cnt_ff + 2'h1;
        end
      end
      ST_MEM:
      begin
        if (strobes_off)
        begin
          nxt_sel   = 1'b0;
          nxt_state = ST_IDLE;
        end
        else
        begin
          nxt_ack_n  = ~mem_ack;
          nxt_rdce_n = ~mem_rdce;
        end
      end
      ST_END:
      begin
        if (strobes_off)
        begin
          nxt_sel   = 1'b0;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_sel   = 1'b0;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff   <= ST_IDLE;
      waddr_ff   <= '0;
      mode_ff    <= MODE_RESET;
      cnt_ff     <= 2'h0;
      mode_wr_ff <= 1'b0;
      sel_ff     <= 1'b0;
      ack_n_ff   <= 1'b1;
      rdce_n_ff  <= 1'b1;
      req_ff     <= 1'b0;
      cyc_ff     <= CYC_RD;
      daddr_ff   <= '0;
    end
    else
    begin
      state_ff   <= nxt_state;
      waddr_ff   <= nxt_waddr;
      mode_ff    <= nxt_mode;
      cnt_ff     <= nxt_cnt;
      mode_wr_ff <= nxt_mode_wr;
      sel_ff     <= nxt_sel;
      ack_n_ff   <= nxt_ack_n;
      rdce_n_ff  <= nxt_rdce_n;
      req_ff     <= nxt_req;
      cyc_ff     <= nxt_cyc;
      daddr_ff   <= nxt_daddr;
    end
  end

  // Pins released unless this controller is selected
  assign bus.ack_n_oe                    = sel_ff;
  assign bus.ack_n_o                     = ack_n_ff;
  assign bus.read_data_latch_enable_n_oe = sel_ff;
  assign bus.read_data_latch_enable_n_o  = rdce_n_ff;

  assign mode_reg   = mode_ff;
  assign mem_req    = req_ff;
  assign mem_cyc    = cyc_ff;
  assign mem_row    = daddr_ff.row;
  assign mem_col    = daddr_ff.col;
  assign mem_bank   = daddr_ff.bank;
  assign mem_active = (state_ff == ST_MEM);

endmodule

// >>> hw/dchb_host.sv
// Processor and address decoder end of the multiplexed bus
module dchb_host
(
  input  wire logic                          ref_clk,
  input  wire logic                          arst_n,
  dchb_bus_if.host                           bus,
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire logic                          cmd_write,
  input  wire logic                          cmd_burst,
  input  wire logic                          cmd_mode,
  input  wire logic [dchb_pkg::AD_W-1:0]     cmd_addr,
  input  wire logic [1:0]                    cmd_addr_lo,
  input  wire logic [dchb_pkg::WDATA_W-1:0]  cmd_wdata,
  output logic                               done,
  output logic                               rdce_seen
);
  import dchb_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_ALE  = 3'h2,
    H_STRB = 3'h4
  } dchb_host_state_e;

  dchb_host_state_e  state_ff, nxt_state;
  logic [AD_W-1:0]   ad_ff, nxt_ad;
  logic [AD_W-1:0]   data_ff, nxt_data;
  logic [1:0]        lo_ff, nxt_lo;
  logic              write_ff, nxt_write;
  logic              burst_ff, nxt_burst;
  logic              mode_ff, nxt_mode;
  logic              done_ff, nxt_done;
  logic              rdce_ff, nxt_rdce;
  logic [WDATA_W-1:0] clean_wdata;

  always_comb
  begin
    clean_wdata = cmd_wdata;
    if (cmd_mode)
    begin
      clean_wdata[MODE_RSVD_LO] = 1'b0;
      clean_wdata[MODE_RSVD_HI] = 1'b0;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_ad    = ad_ff;
    nxt_data  = data_ff;
    nxt_lo    = lo_ff;
    nxt_write = write_ff;
    nxt_burst = burst_ff;
    nxt_mode  = mode_ff;
    nxt_done  = 1'b0;
    nxt_rdce  = rdce_ff;
    case (state_ff)
      H_IDLE:
      begin
        if (cmd_valid)
        begin
          nxt_ad    = cmd_addr;
          nxt_lo    = cmd_addr_lo;
          nxt_data  = {{(AD_W - WDATA_W){1'b0}}, clean_wdata};
          nxt_write = cmd_write;
          nxt_burst = cmd_burst;
          nxt_mode  = cmd_mode;
          nxt_rdce  = 1'b0;
          nxt_state = H_ALE;
        end
      end
      H_ALE:
      begin
        nxt_ad    = write_ff ? data_ff : ad_ff;
        nxt_state = H_STRB;
      end
      H_STRB:
      begin
        if (!bus.read_data_latch_enable_n)
          nxt_rdce = 1'b1;
        if (!bus.ack_n)
        begin
          nxt_done  = 1'b1;
          nxt_state = H_IDLE;
        end
      end
      default:
      begin
        nxt_state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= H_IDLE;
      ad_ff    <= '0;
      data_ff  <= '0;
      lo_ff    <= 2'h0;
      write_ff <= 1'b0;
      burst_ff <= 1'b0;
      mode_ff  <= 1'b0;
      done_ff  <= 1'b0;
      rdce_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ad_ff    <= nxt_ad;
      data_ff  <= nxt_data;
      lo_ff    <= nxt_lo;
      write_ff <= nxt_write;
      burst_ff <= nxt_burst;
      mode_ff  <= nxt_mode;
      done_ff  <= nxt_done;
      rdce_ff  <= nxt_rdce;
    end
  end

  // Decoder selects held from address phase to acknowledge
  assign bus.ale                    = (state_ff == H_ALE);
  assign bus.cs_n                   = (state_ff == H_IDLE);
  assign bus.mode_register_select_n = (state_ff == H_IDLE) | ~mode_ff;
  assign bus.rd_n                   = ~((state_ff == H_STRB) & ~write_ff);
  assign bus.wr_n                   = ~((state_ff == H_STRB) & write_ff);
  assign bus.burst_or_near_write_n  = ~((state_ff == H_STRB) & burst_ff);
  assign bus.ad                     = ad_ff;
  assign bus.addr_lo                = lo_ff;
  assign cmd_ready                  = (state_ff == H_IDLE);
  assign done                       = done_ff;
  assign rdce_seen                  = rdce_ff;

endmodule

// >>> hw/dchb_pkg.sv
// Shared constants, types and address mapping for the host bus interface
package dchb_pkg;

  localparam int          AD_W          = 26;
  localparam int          MODE_W        = 16;
  localparam int          WADDR_W       = 24;
  localparam int          DADDR_W       = 11;
  localparam int          BANKS         = 4;
  localparam int          WDATA_W       = 16;

  localparam logic [15:0] MODE_RESET    = 16'h6CB0;
  localparam int          MODE_DZ_LSB   = 0;
  localparam int          MODE_INLV_BIT = 2;
  localparam int          MODE_RSVD_LO  = 9;
  localparam int          MODE_RSVD_HI  = 15;
  localparam int          MODE_WR_CYC   = 3;

  localparam logic [1:0]  DZ_256K       = 2'h0;
  localparam logic [1:0]  DZ_1M         = 2'h1;

  typedef enum logic [1:0] {
    CYC_RD       = 2'h0,
    CYC_WR       = 2'h1,
    CYC_BURST_RD = 2'h2,
    CYC_NEAR_WR  = 2'h3
  } dchb_cyc_e;

  typedef struct packed {
    logic [DADDR_W-1:0] row;
    logic [DADDR_W-1:0] col;
    logic [BANKS-1:0]   bank;
  } dchb_dram_addr_s;

  // Word address to row, column and one-hot bank
  function automatic dchb_dram_addr_s map_addr(input logic [WADDR_W-1:0] wa,
                                                input logic [1:0]         dz,
                                                input logic               inlv);
    dchb_dram_addr_s r;
    logic [WADDR_W-1:0] sh;
    logic [1:0]         bk;
    int                 n;
    n    = (dz == DZ_256K) ? 9 : ((dz == DZ_1M) ? 10 : 11);
    sh   = inlv ? (wa >> 1) : wa;
    r.col = DADDR_W'(sh & ((WADDR_W'(1) << n) - WADDR_W'(1)));
    r.row = DADDR_W'((sh >> n) & ((WADDR_W'(1) << n) - WADDR_W'(1)));
    bk    = inlv ? {sh[(2 * n) % WADDR_W], wa[0]} : 2'((sh >> (2 * n)) & WADDR_W'(3));
    r.bank = BANKS'(1) << bk;
    return r;
  endfunction

endpackage

// >>> verif/dchb_bus_asserts.sv
// Concurrent checks on the bus joining host and controller ends
module dchb_bus_asserts (
  input wire logic                      ref_clk,
  input wire logic                      arst_n,
  input wire logic                      ale,
  input wire logic                      rd_n,
  input wire logic                      wr_n,
  input wire logic                      cs_n,
  input wire logic                      mode_register_select_n,
  input wire logic [dchb_pkg::AD_W-1:0] ad,
  input wire logic                      read_data_latch_enable_n_oe,
  input wire logic                      ack_n_oe,
  input wire logic                      ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import dchb_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  AST_ACK_OE_SEL: assert property (ack_n_oe |-> !cs_n || !$past(cs_n))
    else $error("ack driven without chip select");
  AST_RDCE_OE_SEL: assert property (read_data_latch_enable_n_oe |-> !cs_n || !$past(cs_n))
    else $error("read enable driven without chip select");
  AST_OE_ON_SELECT: assert property ($fell(rd_n & wr_n) && !cs_n
    |-> ##1 (ack_n_oe && read_data_latch_enable_n_oe))
    else $error("outputs not driven for selected access");
  AST_OE_HOLD: assert property (ack_n_oe && !(rd_n && wr_n) |=> ack_n_oe)
    else $error("ack released during strobe");
  AST_OE_RELEASE: assert property ((ack_n_oe || read_data_latch_enable_n_oe) && rd_n && wr_n
    |=> !ack_n_oe && !read_data_latch_enable_n_oe)
    else $error("outputs not released after strobes");
  AST_MODE_ACK_THREE: assert property ($fell(rd_n & wr_n) && !cs_n && !mode_register_select_n
    |-> ack_n ##1 ack_n ##1 !ack_n ##1 ack_n)
    else $error("mode access ack not in third cycle");
  AST_ACK_IN_ACCESS: assert property (!ack_n |-> !$past(rd_n) || !$past(wr_n))
    else $error("ack outside an access");
  AST_MODE_DATA_ZERO: assert property (!wr_n && !cs_n && !mode_register_select_n
    |-> ad[25:16] == 10'h000 && !ad[15] && !ad[9])
    else $error("mode write data not cleared");
  AST_MODE_REGISTER_SELECT_WITH_CS: assert property (!mode_register_select_n |-> !cs_n)
    else $error("mode select without chip select");
  AST_ALE_NO_STROBE: assert property (ale |-> rd_n && wr_n)
    else $error("strobe during address latch");
endmodule

// >>> verif/dram_ctrl_host_bus_interface_test.sv
// Self-checking bench joining the host end and the controller end
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); \
    end \
  end

module dram_ctrl_host_bus_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dchb_pkg::*;

  localparam logic [AD_W-1:0] MEM_ADDR  = 26'h2F3_5A70;
  localparam logic [AD_W-1:0] MODE_ADDR = 26'h3F0_0000;

  logic                ref_clk   = 1'b0;
  logic                arst_n    = 1'b0;
  logic                cmd_valid = 1'b0;
  logic                cmd_write = 1'b0;
  logic                cmd_burst = 1'b0;
  logic                cmd_mode  = 1'b0;
  logic [AD_W-1:0]     cmd_addr  = '0;
  logic [1:0]          cmd_addr_lo = 2'h0;
  logic [WDATA_W-1:0]  cmd_wdata = '0;
  logic                mem_ack   = 1'b0;
  logic                mem_rdce  = 1'b0;
  logic [1:0]          resp_cnt  = 2'h0;
  logic                cmd_ready, done, rdce_seen, mem_req, mem_active, cap_act;
  logic [MODE_W-1:0]   mode_reg;
  dchb_cyc_e           mem_cyc, cap_cyc;
  logic [DADDR_W-1:0]  mem_row, mem_col;
  logic [BANKS-1:0]    mem_bank;
  dchb_dram_addr_s     cap_addr;
  int                  miscompares  = 0;
  int                  total_checks = 0;

  dchb_bus_if bus ();

  dchb_device i_dchb_device (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus),
    .mode_reg(mode_reg), .mem_req(mem_req), .mem_cyc(mem_cyc), .mem_row(mem_row),
    .mem_col(mem_col), .mem_bank(mem_bank), .mem_active(mem_active),
    .mem_ack(mem_ack), .mem_rdce(mem_rdce));

  dchb_host i_dchb_host (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_burst(cmd_burst), .cmd_mode(cmd_mode), .cmd_addr(cmd_addr),
    .cmd_addr_lo(cmd_addr_lo), .cmd_wdata(cmd_wdata), .done(done), .rdce_seen(rdce_seen));

  dchb_bus_asserts i_dchb_bus_asserts (.ref_clk(ref_clk), .arst_n(arst_n),
    .ale(bus.ale), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .cs_n(bus.cs_n),
    .mode_register_select_n(bus.mode_register_select_n), .ad(bus.ad),
    .read_data_latch_enable_n_oe(bus.read_data_latch_enable_n_oe),
    .ack_n_oe(bus.ack_n_oe), .ack_n(bus.ack_n));

  always #25 ref_clk = ~ref_clk;

  // Memory side: read enable on reads, then ack a few cycles after each request
  always @(negedge ref_clk)
  begin
    mem_ack  <= (resp_cnt == 2'h1);
    mem_rdce <= (resp_cnt == 2'h2) && (cap_cyc[0] === 1'b0);
    if (mem_req === 1'b1)
    begin
      cap_addr <= {mem_row, mem_col, mem_bank};
      cap_act  <= mem_active;
      cap_cyc  <= mem_cyc;
      resp_cnt <= 2'h3;
    end
    else if (resp_cnt != 2'h0)
      resp_cnt <= resp_cnt - 2'h1;
  end

  function automatic dchb_dram_addr_s exp_map(input logic [23:0] wa, input int n,
                                              input logic inlv);
    logic [23:0]     s;
    logic [1:0]      b;
    dchb_dram_addr_s r;
    s      = inlv ? (wa >> 1) : wa;
    b      = inlv ? {s[2 * n], wa[0]} : s[2 * n +: 2];
    r.col  = DADDR_W'(s % (24'h1 << n));
    r.row  = DADDR_W'((s >> n) % (24'h1 << n));
    r.bank = 4'h1 << b;
    return r;
  endfunction

  task automatic summarize;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic run_cmd(input logic w, input logic b, input logic m,
                         input logic [AD_W-1:0] a, input logic [1:0] lo,
                         input logic [WDATA_W-1:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (cmd_ready !== 1'b1)
    begin
      `CHK(cmd_ready, 1'b1);
      summarize();
    end
    {cmd_write, cmd_burst, cmd_mode, cmd_addr, cmd_addr_lo, cmd_wdata} = {w, b, m, a, lo, d};
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (done !== 1'b1)
    begin
      `CHK(done, 1'b1);
      summarize();
    end
  endtask

  task automatic t_reset;
    `CHK(mode_reg, MODE_RESET);
    `CHK(bus.ack_n, 1'b1);
    `CHK(bus.read_data_latch_enable_n, 1'b1);
  endtask

  // Every size and organisation, every cycle kind, reserved bits set on purpose
  task automatic t_map;
    logic [MODE_W-1:0] cfg;
    logic [23:0]       wa;
    logic [2:0]        kb;
    // Boot order: largest size first, then the sizes actually probed
    cfg = {MODE_RESET[15:3], 1'b0, 2'h2};
    run_cmd(1'b1, 1'b0, 1'b1, MODE_ADDR, 2'h0, cfg);
    `CHK(mode_reg, cfg);
    for (int k = 0; k < 6; k++)
    begin
      kb  = 3'(k);
      cfg = {MODE_RESET[15:3], kb[0], 2'(k / 2)};
      run_cmd(1'b1, 1'b0, 1'b1, MODE_ADDR, 2'h0, cfg | 16'h8200);
      `CHK(mode_reg, cfg);
      run_cmd(1'b0, 1'b0, 1'b1, MODE_ADDR, 2'h0, 16'h0000);
      `CHK(mode_reg, cfg);
      `CHK(mem_active, 1'b0);
      wa = {MEM_ADDR[25:4], kb[1:0]};
      run_cmd(kb[0], kb[1], 1'b0, MEM_ADDR, kb[1:0], 16'h5A3C);
      `CHK(cap_addr, exp_map(wa, 9 + k / 2, kb[0]));
      `CHK(cap_cyc, dchb_cyc_e'(kb[1:0]));
      `CHK(cap_act, 1'b1);
      `CHK(rdce_seen, ~kb[0]);
      `CHK(mode_reg, cfg);
    end
  endtask

  initial
  begin
    repeat (12) @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_map();
    summarize();
  end
endmodule
